// >>> hdl/mdfc_consts.svh
`ifndef MDFC_CONSTS_SVH
`define MDFC_CONSTS_SVH

// register addresses on the register port
`define MDFC_ADDR_MOTION_CTL  8'h27
`define MDFC_ADDR_BUFFER_CTL  8'h28
`define MDFC_CTL_RESET        8'h00
`define MDFC_RDATA_UNMAPPED   8'h00

// motion_detect_control fields
`define MDFC_MOTION_EN_BIT    0
`define MDFC_MOTION_REF_BIT   1
`define MDFC_STILL_EN_BIT     2
`define MDFC_STILL_REF_BIT    3
`define MDFC_SEQ_LO_BIT       4
`define MDFC_SEQ_HI_BIT       5

// sample_buffer_control fields
`define MDFC_FMODE_LO_BIT     0
`define MDFC_FMODE_HI_BIT     1
`define MDFC_FTEMP_BIT        2
`define MDFC_TOPBIT_BIT       3

// buffer mode codes and their one-hot decode
`define MDFC_FMODE_OFF        2'b00
`define MDFC_FMODE_OLDEST     2'b01
`define MDFC_FMODE_STREAM     2'b10
`define MDFC_FMODE_TRIGGER    2'b11
`define MDFC_FOH_OFF          4'h1
`define MDFC_FOH_OLDEST       4'h2
`define MDFC_FOH_STREAM       4'h4
`define MDFC_FOH_TRIGGER      4'h8

// still counter
`define MDFC_CNT_ZERO         16'h0000
`define MDFC_CNT_ONE          16'h0001
`define MDFC_CNT_INC          17'h00001

`endif

// >>> hdl/mdfc_pkg.sv
package mdfc_pkg;

    typedef enum logic [1:0] {
        MDFC_SEQ_MOTION = 2'b01,
        MDFC_SEQ_STILL  = 2'b10
    } mdfc_seq_e;

    typedef logic signed [11:0] mdfc_axis_t;
    typedef logic [10:0]        mdfc_thresh_t;

endpackage

// >>> hdl/mdfc_axis_cmp.sv
`timescale 1ns/100ps
`include "mdfc_consts.svh"

module mdfc_axis_cmp
    import mdfc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    input  wire mdfc_axis_t   sx,
    input  wire mdfc_axis_t   sy,
    input  wire mdfc_axis_t   sz,
    input  wire mdfc_axis_t   rx,
    input  wire mdfc_axis_t   ry,
    input  wire mdfc_axis_t   rz,
    input  wire logic         motion_use_ref,
    input  wire logic         still_use_ref,
    input  wire mdfc_thresh_t motion_th,
    input  wire mdfc_thresh_t still_th,
    output logic              out_valid,
    output logic              any_over,
    output logic              all_under
);

    mdfc_axis_t  s_arr [3];
    mdfc_axis_t  r_arr [3];
    logic [2:0]  over_vec;
    logic [2:0]  under_vec;
    logic        out_valid_reg;
    logic        any_over_reg;
    logic        all_under_reg;

    assign s_arr[0] = sx;
    assign s_arr[1] = sy;
    assign s_arr[2] = sz;
    assign r_arr[0] = rx;
    assign r_arr[1] = ry;
    assign r_arr[2] = rz;

    // 13-bit difference so a full-scale swing never wraps
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_axis
            logic signed [12:0] s_ext;
            logic signed [12:0] m_diff;
            logic signed [12:0] s_diff;
            logic        [12:0] m_mag;
            logic        [12:0] s_mag;
            assign s_ext  = {s_arr[g][11], s_arr[g]};
            assign m_diff = motion_use_ref ?
                            13'(s_ext - {r_arr[g][11], r_arr[g]}) : s_ext;
            assign s_diff = still_use_ref ?
                            13'(s_ext - {r_arr[g][11], r_arr[g]}) : s_ext;
            assign m_mag  = m_diff[12] ? 13'(-m_diff) : m_diff;
            assign s_mag  = s_diff[12] ? 13'(-s_diff) : s_diff;
            assign over_vec[g]  = m_mag > {2'b00, motion_th};
            assign under_vec[g] = s_mag < {2'b00, still_th};
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid_reg <= 1'b0;
            any_over_reg  <= 1'b0;
            all_under_reg <= 1'b0;
        end else begin
            out_valid_reg <= in_valid;
            any_over_reg  <= |over_vec;
            all_under_reg <= &under_vec;
        end
    end

    assign out_valid = out_valid_reg;
    assign any_over  = any_over_reg;
    assign all_under = all_under_reg;

endmodule // mdfc_axis_cmp

// >>> hdl/mdfc_motion_regs.sv
`timescale 1ns/100ps
`include "mdfc_consts.svh"

module mdfc_motion_regs
    import mdfc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         reg_rd,
    output logic [7:0]        reg_rdata,
    output logic              reg_rvalid,
    input  wire logic         status_rd,
    input  wire logic         sample_valid,
    input  wire mdfc_axis_t   sample_x,
    input  wire mdfc_axis_t   sample_y,
    input  wire mdfc_axis_t   sample_z,
    input  wire mdfc_thresh_t motion_threshold,
    input  wire mdfc_thresh_t still_threshold,
    input  wire logic [15:0]  still_sample_count,
    output logic              motion_flag,
    output logic              still_flag,
    output logic              motion_armed,
    output logic              still_armed,
    output logic              sleep_req,
    output logic [3:0]        fifo_mode_onehot,
    output logic              fifo_temp_store,
    output logic              sample_count_top_bit
);

    logic [7:0]  motion_detect_control_reg;
    logic [7:0]  sample_buffer_control_reg;
    logic [7:0]  reg_rdata_reg;
    logic        reg_rvalid_reg;
    mdfc_seq_e   seq_reg;
    mdfc_seq_e   seq_next;
    logic        motion_armed_reg;
    logic        still_armed_reg;
    logic        motion_flag_reg;
    logic        still_flag_reg;
    logic        sleep_req_reg;
    logic [3:0]  fifo_mode_onehot_reg;
    logic [15:0] still_cnt_reg;
    logic        ref_load_reg;
    mdfc_axis_t  ref_x_reg;
    mdfc_axis_t  ref_y_reg;
    mdfc_axis_t  ref_z_reg;

    logic        motion_en;
    logic        still_en;
    logic [1:0]  seq_code;
    logic        linked_active;
    logic        loop_active;
    logic        motion_arm_now;
    logic        still_arm_now;
    logic        cmp_valid;
    logic        cmp_over;
    logic        cmp_under;
    logic        motion_hit;
    logic        still_hit;
    logic [15:0] still_target;
    logic [16:0] still_cnt_inc;
    logic        wr_motion;

    assign motion_en = motion_detect_control_reg[`MDFC_MOTION_EN_BIT];
    assign still_en  = motion_detect_control_reg[`MDFC_STILL_EN_BIT];
    assign seq_code = motion_detect_control_reg[`MDFC_SEQ_HI_BIT:
                                                `MDFC_SEQ_LO_BIT];
    assign linked_active = seq_code[0] && motion_en && still_en;
    assign loop_active   = linked_active && seq_code[1];
    assign wr_motion = reg_wr && (reg_addr == `MDFC_ADDR_MOTION_CTL);

    // register writes; unused upper bits kept as plain storage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            motion_detect_control_reg <= `MDFC_CTL_RESET;
            sample_buffer_control_reg <= `MDFC_CTL_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `MDFC_ADDR_MOTION_CTL) begin
                motion_detect_control_reg <= reg_wdata;
            end
            if (reg_addr == `MDFC_ADDR_BUFFER_CTL) begin
                sample_buffer_control_reg <= reg_wdata;
            end
        end
    end

    // read data registered, valid one cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_reg  <= `MDFC_RDATA_UNMAPPED;
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rvalid_reg <= reg_rd;
            if (reg_rd) begin
                if (reg_addr == `MDFC_ADDR_MOTION_CTL) begin
                    reg_rdata_reg <= motion_detect_control_reg;
                end else if (reg_addr == `MDFC_ADDR_BUFFER_CTL) begin
                    reg_rdata_reg <= sample_buffer_control_reg;
                end else begin
                    reg_rdata_reg <= `MDFC_RDATA_UNMAPPED;
                end
            end
        end
    end

    // arming: default runs each enabled detector on its own
    always_comb begin
        motion_arm_now = motion_en && (!linked_active ||
                         seq_reg == MDFC_SEQ_MOTION);
        still_arm_now  = still_en && (!linked_active ||
                         seq_reg == MDFC_SEQ_STILL);
    end

    mdfc_axis_cmp u_cmp (
        .clk            (clk),
        .nrst           (nrst),
        .in_valid       (sample_valid),
        .sx             (sample_x),
        .sy             (sample_y),
        .sz             (sample_z),
        .rx             (ref_x_reg),
        .ry             (ref_y_reg),
        .rz             (ref_z_reg),
        .motion_use_ref (motion_detect_control_reg[`MDFC_MOTION_REF_BIT]),
        .still_use_ref  (motion_detect_control_reg[`MDFC_STILL_REF_BIT]),
        .motion_th      (motion_threshold),
        .still_th       (still_threshold),
        .out_valid      (cmp_valid),
        .any_over       (cmp_over),
        .all_under      (cmp_under)
    );

    // a count of zero behaves as one
    assign still_target  = (still_sample_count == `MDFC_CNT_ZERO) ?
                           `MDFC_CNT_ONE : still_sample_count;
    assign still_cnt_inc = {1'b0, still_cnt_reg} + `MDFC_CNT_INC;
    assign motion_hit = cmp_valid && cmp_over && motion_arm_now;
    assign still_hit  = cmp_valid && cmp_under && still_arm_now &&
                        (still_cnt_inc >= {1'b0, still_target});

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            still_cnt_reg <= `MDFC_CNT_ZERO;
        end else if (!still_arm_now || still_hit) begin
            still_cnt_reg <= `MDFC_CNT_ZERO;
        end else if (cmp_valid) begin
            still_cnt_reg <= cmp_under ?
                             still_cnt_inc[15:0] : `MDFC_CNT_ZERO;
        end
    end

    // sequencer; outside linked it parks on the motion side
    always_comb begin
        seq_next = seq_reg;
        if (!linked_active) begin
            seq_next = MDFC_SEQ_MOTION;
        end else begin
            unique case (seq_reg)
                MDFC_SEQ_MOTION: begin
                    if (motion_hit) begin
                        seq_next = MDFC_SEQ_STILL;
                    end
                end
                MDFC_SEQ_STILL: begin
                    if (still_hit) begin
                        seq_next = MDFC_SEQ_MOTION;
                    end
                end
                default: seq_next = MDFC_SEQ_MOTION;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_reg          <= MDFC_SEQ_MOTION;
            motion_armed_reg <= 1'b0;
            still_armed_reg  <= 1'b0;
        end else begin
            seq_reg          <= seq_next;
            motion_armed_reg <= motion_arm_now;
            still_armed_reg  <= still_arm_now;
        end
    end

    // reference retaken after any motion control write or hand-over
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ref_load_reg <= 1'b1;
            ref_x_reg    <= '0;
            ref_y_reg    <= '0;
            ref_z_reg    <= '0;
        end else begin
            if (wr_motion || seq_next != seq_reg) begin
                ref_load_reg <= 1'b1;
            end else if (sample_valid && ref_load_reg) begin
                ref_load_reg <= 1'b0;
            end
            if (sample_valid && ref_load_reg) begin
                ref_x_reg <= sample_x;
                ref_y_reg <= sample_y;
                ref_z_reg <= sample_z;
            end
        end
    end

    // flags: set wins over any clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            motion_flag_reg <= 1'b0;
            still_flag_reg  <= 1'b0;
        end else begin
            if (motion_hit) begin
                motion_flag_reg <= 1'b1;
            end else if (loop_active || status_rd) begin
                motion_flag_reg <= 1'b0;
            end
            if (still_hit) begin
                still_flag_reg <= 1'b1;
            end else if (loop_active || status_rd) begin
                still_flag_reg <= 1'b0;
            end
        end
    end

    // sleep request only exists with linked or loop sequencing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleep_req_reg <= 1'b0;
        end else if (!linked_active || motion_hit) begin
            sleep_req_reg <= 1'b0;
        end else if (still_hit) begin
            sleep_req_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fifo_mode_onehot_reg <= `MDFC_FOH_OFF;
        end else begin
            unique case (sample_buffer_control_reg[`MDFC_FMODE_HI_BIT:
                                                  `MDFC_FMODE_LO_BIT])
                `MDFC_FMODE_OFF:     fifo_mode_onehot_reg <= `MDFC_FOH_OFF;
                `MDFC_FMODE_OLDEST:  fifo_mode_onehot_reg <= `MDFC_FOH_OLDEST;
                `MDFC_FMODE_STREAM:  fifo_mode_onehot_reg <= `MDFC_FOH_STREAM;
                `MDFC_FMODE_TRIGGER: fifo_mode_onehot_reg <= `MDFC_FOH_TRIGGER;
            endcase
        end
    end

    assign reg_rdata            = reg_rdata_reg;
    assign reg_rvalid           = reg_rvalid_reg;
    assign motion_flag          = motion_flag_reg;
    assign still_flag           = still_flag_reg;
    assign motion_armed         = motion_armed_reg;
    assign still_armed          = still_armed_reg;
    assign sleep_req            = sleep_req_reg;
    assign fifo_mode_onehot     = fifo_mode_onehot_reg;
    assign fifo_temp_store      =
        sample_buffer_control_reg[`MDFC_FTEMP_BIT];
    assign sample_count_top_bit =
        sample_buffer_control_reg[`MDFC_TOPBIT_BIT];

    property p_default_both;
        @(posedge clk) disable iff (!nrst)
        (!linked_active && motion_en && still_en) |=>
            (motion_armed && still_armed);
    endproperty
    a_default_both: assert property (p_default_both)
        else $error("default mode must arm both detectors");

    property p_no_sleep_default;
        @(posedge clk) disable iff (!nrst)
        !linked_active |=> !sleep_req;
    endproperty
    a_no_sleep_default: assert property (p_no_sleep_default)
        else $error("sleep request raised in default mode");

    property p_linked_one_armed;
        @(posedge clk) disable iff (!nrst)
        linked_active |=> !(motion_armed && still_armed);
    endproperty
    a_linked_one_armed: assert property (p_linked_one_armed)
        else $error("both detectors armed while linked");

    property p_loop_self_clear;
        @(posedge clk) disable iff (!nrst)
        (motion_flag && loop_active && !motion_hit) |=> !motion_flag;
    endproperty
    a_loop_self_clear: assert property (p_loop_self_clear)
        else $error("loop mode flag not cleared internally");

    property p_flag_held;
        @(posedge clk) disable iff (!nrst)
        (still_flag && !loop_active && !status_rd) |=> still_flag;
    endproperty
    a_flag_held: assert property (p_flag_held)
        else $error("flag dropped without status read");

    property p_still_needs_en;
        @(posedge clk) disable iff (!nrst)
        (!still_en && !still_flag) |=> !still_flag;
    endproperty
    a_still_needs_en: assert property (p_still_needs_en)
        else $error("still flag set while disabled");

    property p_motion_needs_en;
        @(posedge clk) disable iff (!nrst)
        (!motion_en && !motion_flag) |=> !motion_flag;
    endproperty
    a_motion_needs_en: assert property (p_motion_needs_en)
        else $error("motion flag set while disabled");

    property p_stream_decode;
        @(posedge clk) disable iff (!nrst)
        (sample_buffer_control_reg[1:0] == `MDFC_FMODE_STREAM) |=>
            (fifo_mode_onehot == `MDFC_FOH_STREAM);
    endproperty
    a_stream_decode: assert property (p_stream_decode)
        else $error("stream mode decoded wrongly");

    property p_count_restart;
        @(posedge clk) disable iff (!nrst)
        (cmp_valid && !cmp_under) |=> (still_cnt_reg == `MDFC_CNT_ZERO);
    endproperty
    a_count_restart: assert property (p_count_restart)
        else $error("still count not restarted by over sample");

    property p_write_read;
        @(posedge clk) disable iff (!nrst)
        (reg_wr && !reg_rd && reg_addr == `MDFC_ADDR_BUFFER_CTL) ##1 !reg_wr
            ##1 (reg_rd && !reg_wr && reg_addr == `MDFC_ADDR_BUFFER_CTL) |=>
            (reg_rvalid && reg_rdata == $past(reg_wdata, 3));
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("buffer control read back differs from write");

    c_linked_to_still: cover property (@(posedge clk) disable iff (!nrst)
        linked_active && seq_reg == MDFC_SEQ_MOTION ##1
        seq_reg == MDFC_SEQ_STILL);
    c_loop_pulse: cover property (@(posedge clk) disable iff (!nrst)
        loop_active && $rose(motion_flag) ##1 !motion_flag);
    c_sleep: cover property (@(posedge clk) disable iff (!nrst)
        $rose(sleep_req));
    c_status_clear: cover property (@(posedge clk) disable iff (!nrst)
        still_flag && status_rd ##1 !still_flag);

endmodule // mdfc_motion_regs

// >>> sim/mdfc_host_model.sv
`timescale 1ns/100ps

module mdfc_host_model (
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic            status_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
        status_rd = 1'b0;
    end

    // address and data inverted once released, so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        ok = reg_rvalid;
        d  = reg_rdata;
    endtask

    // status register read happens outside the block, only its pulse here
    task automatic ack();
        @(posedge clk);
        status_rd <= 1'b1;
        @(posedge clk);
        status_rd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule // mdfc_host_model

// >>> sim/motion_fifo_control_regs_bench.sv
`timescale 1ns/100ps

module motion_fifo_control_regs_bench;
    import mdfc_pkg::*;
    logic         clk, nrst, reg_wr, reg_rd, reg_rvalid, status_rd;
    logic         sample_valid, motion_flag, still_flag, motion_armed;
    logic         still_armed, sleep_req, fifo_temp_store;
    logic         sample_count_top_bit, mf, sf, ok;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0]   fifo_mode_onehot;
    logic [15:0]  still_sample_count;
    mdfc_axis_t   sample_x, sample_y, sample_z;
    mdfc_thresh_t motion_threshold, still_threshold;
    mdfc_axis_t   zs [6];
    int           num_errors, total_checks;

    mdfc_motion_regs i_dut (.clk, .nrst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .reg_rvalid, .status_rd, .sample_valid,
        .sample_x, .sample_y, .sample_z, .motion_threshold,
        .still_threshold, .still_sample_count, .motion_flag, .still_flag,
        .motion_armed, .still_armed, .sleep_req, .fifo_mode_onehot,
        .fifo_temp_store, .sample_count_top_bit);

    mdfc_host_model i_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_rvalid, .status_rd);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d, ok);
        chk("reg_rvalid", 16'h1, {15'h0, ok});
        chk("reg_rdata", {8'h0, exp}, {8'h0, d});
    endtask

    // flags are watched over a window, so a one-cycle pulse is caught too
    task automatic smp(input mdfc_axis_t x, input mdfc_axis_t y,
                       input mdfc_axis_t z);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_x     <= x;
        sample_y     <= y;
        sample_z     <= z;
        @(posedge clk);
        sample_valid <= 1'b0;
        sample_x     <= ~x;
        sample_y     <= ~y;
        sample_z     <= ~z;
        mf = 1'b0;
        sf = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1;
            mf = mf | motion_flag;
            sf = sf | still_flag;
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #40000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        sample_valid = 1'b0;
        sample_x = 12'h000;
        sample_y = 12'h000;
        sample_z = 12'h000;
        motion_threshold = 11'h064;
        still_threshold = 11'h032;
        still_sample_count = 16'h0001;
        zs = '{12'h00a, 12'h00a, 12'hfce, 12'h00a, 12'h00a, 12'h00a};
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        settle();
        chk("fifo_mode_onehot", 16'h1, {12'h0, fifo_mode_onehot});
        rd_chk(8'h27, 8'h00);
        rd_chk(8'h28, 8'h00);
        for (int i = 0; i < 2; i++) begin
            i_host.wr(8'h27, i ? 8'ha5 : 8'hff);
            i_host.wr(8'h31, 8'h00);
            i_host.wr(8'h28, i ? 8'h5a : 8'hff);
            rd_chk(8'h28, i ? 8'h5a : 8'hff);
            rd_chk(8'h27, i ? 8'ha5 : 8'hff);
            rd_chk(8'h31, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            i_host.wr(8'h28, {4'h9, i[1], i[0], i[1:0]});
            settle();
            chk("fifo_mode_onehot", 16'h1 << i, {12'h0, fifo_mode_onehot});
            chk("fifo_temp_store", {15'h0, i[0]}, {15'h0, fifo_temp_store});
            chk("top_bit", {15'h0, i[1]}, {15'h0, sample_count_top_bit});
        end
        i_host.wr(8'h27, 8'h01);
        smp(12'h064, 12'h000, 12'h000);
        chk("motion at limit", 16'h0, {15'h0, mf});
        smp(12'h000, 12'hf9c, 12'h000);
        chk("motion at minus limit", 16'h0, {15'h0, mf});
        smp(12'h000, 12'h000, 12'hf9b);
        chk("motion over", 16'h1, {15'h0, mf});
        chk("motion_flag held", 16'h1, {15'h0, motion_flag});
        smp(12'h00a, 12'h00a, 12'h00a);
        chk("still while off", 16'h0, {15'h0, sf});
        i_host.ack();
        chk("motion_flag cleared", 16'h0, {15'h0, motion_flag});
        i_host.wr(8'h27, 8'h04);
        smp(12'h0c8, 12'h000, 12'h000);
        chk("motion while off", 16'h0, {15'h0, mf});
        @(posedge clk);
        still_sample_count <= 16'h0003;
        for (int k = 0; k < 6; k++) begin
            smp(12'h00a, 12'h00a, zs[k]);
            chk("still count", {15'h0, k == 5}, {15'h0, sf});
        end
        i_host.ack();
        still_sample_count <= 16'h0001;
        i_host.wr(8'h27, 8'h0c);
        smp(12'h1f4, 12'h000, 12'h000);
        i_host.ack();
        smp(12'h212, 12'h000, 12'h000);
        chk("still referenced", 16'h1, {15'h0, sf});
        i_host.ack();
        i_host.wr(8'h27, 8'h03);
        smp(12'h1f4, 12'h000, 12'h000);
        smp(12'h226, 12'h000, 12'h000);
        chk("motion referenced", 16'h0, {15'h0, mf});
        smp(12'h28a, 12'h000, 12'h000);
        chk("motion referenced", 16'h1, {15'h0, mf});
        i_host.ack();
        i_host.wr(8'h27, 8'h15);
        settle();
        chk("motion_armed", 16'h1, {15'h0, motion_armed});
        chk("still_armed", 16'h0, {15'h0, still_armed});
        smp(12'h0c8, 12'h000, 12'h000);
        chk("still_armed", 16'h1, {15'h0, still_armed});
        chk("motion_armed", 16'h0, {15'h0, motion_armed});
        smp(12'h00a, 12'h000, 12'h000);
        chk("still_flag", 16'h1, {15'h0, still_flag});
        chk("motion_flag held", 16'h1, {15'h0, motion_flag});
        chk("sleep_req", 16'h1, {15'h0, sleep_req});
        i_host.ack();
        chk("flags cleared", 16'h0, {14'h0, motion_flag, still_flag});
        i_host.wr(8'h27, 8'h35);
        smp(12'h0c8, 12'h000, 12'h000);
        chk("motion pulse", 16'h1, {15'h0, mf});
        chk("motion_flag self clear", 16'h0, {15'h0, motion_flag});
        smp(12'h00a, 12'h000, 12'h000);
        chk("still pulse", 16'h1, {15'h0, sf});
        chk("still_flag self clear", 16'h0, {15'h0, still_flag});
        i_host.wr(8'h27, 8'h31);
        settle();
        chk("sleep_req", 16'h0, {15'h0, sleep_req});
        smp(12'h0c8, 12'h000, 12'h000);
        chk("motion_flag held", 16'h1, {15'h0, motion_flag});
        chk("motion_armed", 16'h1, {15'h0, motion_armed});
        i_host.ack();
        i_host.wr(8'h27, 8'h05);
        smp(12'h0c8, 12'h000, 12'h000);
        smp(12'h00a, 12'h000, 12'h000);
        chk("both flags held", 16'h3, {14'h0, motion_flag, still_flag});
        chk("sleep_req", 16'h0, {15'h0, sleep_req});
        i_host.ack();
        tally_and_finish();
    end
endmodule // motion_fifo_control_regs_bench
